// >>> verilog/low_voltage_reset_control.sv
// Low-voltage reset control: registers, qualification and reset sequencing
// ****************************************************************
// Summary of operation
// - Only codes 55, 33, 99, AA select a trip voltage; AA is highest.
// - Any other threshold code resets chip after delay and reloads 55.
// - Low-supply reset only after low indication outlasts selected width.
// - Low-supply reset leaves the threshold register unchanged.
// - Width code 0..3 means 8, 32, 64, 128 oscillator periods.
// - Unused bits of width and cause registers read as zero.
// - Cause bit 2 set by every qualified low-supply reset.
// - Cause bit 1 set when the delayed reset for an undefined threshold code fires.
// - Cause flags cleared only by software writing zero.
// - Low-supply detection off while in idle or sleep.
// - Cause bit 0 set by a watchdog-control software reset.
// ****************************************************************
`timescale 1ns/100ps
`default_nettype none

module low_voltage_reset_control #(
  parameter int SRESET_CYC = lvr_pkg::SOFT_RESET_CYC,
  parameter int PULSE_CYC  = lvr_pkg::RESET_PULSE_CYC
) (
  // Clock and power-on reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [lvr_pkg::ADR_W-1:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Analog side and oscillator pins
  input  wire logic        low_supply_i,
  input  wire logic        low_speed_osc_i,
  // Power mode and watchdog event, same clock
  input  wire logic        power_down_i,
  input  wire logic        watchdog_ctrl_reset_i,
  // Outputs
  output logic [7:0]       threshold_code_o,
  output logic             chip_reset_o,
  output logic             irq_o
);
  import lvr_pkg::*;

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  generate
    if (SRESET_CYC < 1 || SRESET_CYC > 4096) begin : g_chk_sr
      $error("SRESET_CYC out of range");
    end
    if (PULSE_CYC < 8 || PULSE_CYC > 4096) begin : g_chk_pl
      $error("PULSE_CYC out of range");
    end
  endgenerate

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic code_valid(input logic [7:0] code);
    code_valid = (code == THR_2V10) || (code == THR_2V55) ||
                 (code == THR_3V15) || (code == THR_3V80);
  endfunction : code_valid

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wb_req_t            req;
  logic               ack_q;
  logic [31:0]        rd_mux;
  logic [31:0]        rd_q;
  logic               req_new;
  logic               take;
  logic               wr_en;
  logic               rd_en;
  logic               hit_thr;
  logic               hit_width;
  logic               hit_cause;
  logic               hit_stat;
  logic               hit_mask;
  logic [7:0]         thr_q;
  logic [7:0]         thr_d;
  logic [1:0]         width_q;
  logic [1:0]         width_d;
  logic [FLAG_W-1:0]  cause_q;
  logic [FLAG_W-1:0]  cause_d;
  logic [FLAG_W-1:0]  stat_q;
  logic [FLAG_W-1:0]  stat_d;
  logic [FLAG_W-1:0]  mask_q;
  logic [FLAG_W-1:0]  mask_d;
  logic [FLAG_W-1:0]  events;
  logic [FLAG_W-1:0]  cause_keep;
  logic               osc_s1_q;
  logic               osc_s2_q;
  logic               osc_s3_q;
  logic               low_s1_q;
  logic               low_s2_q;
  logic               osc_tick;
  logic               lvr_fire;
  logic               bad_code;
  logic               bad_done;
  logic               lvr_evt;
  seq_st_t            st_q;
  seq_st_t            st_d;
  logic [12:0]        cnt_q;
  logic [12:0]        cnt_d;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Preset high: release never fakes a rising oscillator edge
      osc_s1_q <= 1'b1;
      osc_s2_q <= 1'b1;
      osc_s3_q <= 1'b1;
      low_s1_q <= 1'b0;
      low_s2_q <= 1'b0;
    end else begin
      osc_s1_q <= low_speed_osc_i;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      low_s1_q <= low_supply_i;
      low_s2_q <= low_s1_q;
    end
  end

  // Edge taken from the second and third stages
  assign osc_tick = osc_s2_q && !osc_s3_q;

  // ****************************************************************
  // Width qualification
  // ****************************************************************
  low_width_qualifier #(
    .CNT_W (8)
  ) u_qual (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .enable_i     (!power_down_i),
    .low_i        (low_s2_q),
    .tick_i       (osc_tick),
    .width_code_i (width_q),
    .fire_o       (lvr_fire)
  );

  // ****************************************************************
  // Wishbone decode
  // ****************************************************************
  assign req       = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i,
                       sel: sel_i, dat: dat_i};
  assign req_new   = req.cyc && req.stb && !ack_q;
  assign take      = req.cyc && req.stb && ack_q;
  assign wr_en     = take && req.we && req.sel[0];
  assign rd_en     = take && !req.we;
  assign hit_thr   = (req.adr == ADR_THRESHOLD);
  assign hit_width = (req.adr == ADR_WIDTH);
  assign hit_cause = (req.adr == ADR_CAUSE);
  assign hit_stat  = (req.adr == ADR_IRQ_STAT);
  assign hit_mask  = (req.adr == ADR_IRQ_MASK);

  // Unmapped addresses are acknowledged and read zero
  always_comb begin
    rd_mux = '0;
    if (hit_thr) begin
      rd_mux[7:0] = thr_q;
    end else if (hit_width) begin
      rd_mux[1:0] = width_q;
    end else if (hit_cause) begin
      rd_mux[FLAG_W-1:0] = cause_q;
    end else if (hit_stat) begin
      rd_mux[FLAG_W-1:0] = stat_q;
    end else if (hit_mask) begin
      rd_mux[FLAG_W-1:0] = mask_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rd_q  <= '0;
    end else begin
      ack_q <= req_new;
      if (req_new) rd_q <= rd_mux;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rd_q;

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  assign bad_code = !code_valid(thr_q);
  assign bad_done = (st_q == ST_WAIT) && (cnt_q == 13'(SRESET_CYC - 1));
  assign lvr_evt  = lvr_fire;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q + 1'b1;
    case (st_q)
      ST_RUN: begin
        cnt_d = '0;
        if (lvr_fire) begin
          st_d = ST_RESET;
        end else if (bad_code) begin
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (bad_done) begin
          st_d  = ST_RESET;
          cnt_d = '0;
        end
      end
      ST_RESET: begin
        if (cnt_q == 13'(PULSE_CYC - 1)) begin
          st_d  = ST_RUN;
          cnt_d = '0;
        end
      end
      default: begin
        st_d  = ST_RUN;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q  <= ST_RUN;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign chip_reset_o = (st_q == ST_RESET);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Reload beats a software write landing on the same edge
  assign thr_d   = bad_done ? THR_POR :
                   (wr_en && hit_thr) ? req.dat[7:0] : thr_q;
  assign width_d = (wr_en && hit_width) ? req.dat[1:0] : width_q;
  assign mask_d  = (wr_en && hit_mask) ? req.dat[FLAG_W-1:0] : mask_q;

  // ****************************************************************
  // Cause flags and interrupt status
  // ****************************************************************
  assign events = {lvr_evt, bad_done, watchdog_ctrl_reset_i};
  // Software writes zero to clear; hardware only ever sets
  assign cause_keep = (wr_en && hit_cause) ? req.dat[FLAG_W-1:0]
                                           : {FLAG_W{1'b1}};
  assign cause_d = (cause_q & cause_keep) | events;
  // Read clears, but an event on the same edge survives
  assign stat_d  = ((rd_en && hit_stat) ? '0 : stat_q) | events;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_q   <= THR_POR;
      width_q <= WIDTH_POR;
      cause_q <= '0;
      stat_q  <= '0;
      mask_q  <= '0;
    end else begin
      thr_q   <= thr_d;
      width_q <= width_d;
      cause_q <= cause_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
    end
  end

  assign threshold_code_o = thr_q;
  assign irq_o            = |(stat_q & mask_q);

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_bad_code_reload : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_q == ST_RUN && !lvr_fire && bad_code) |=>
      ##(SRESET_CYC) (thr_q == THR_POR && chip_reset_o))
    else $error("bad threshold code not reloaded after delay");

  chk_reset_pulse_len : assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(chip_reset_o) |-> chip_reset_o [*8])
    else $error("chip reset pulse too short");

  // Event during a pulse or a pending reload flags but adds no pulse
  chk_lvr_flag_set : assert property (
    @(posedge clk_i) disable iff (rst_i)
    lvr_fire |=> cause_q[LVR_BIT] && stat_q[LVR_BIT] &&
      (chip_reset_o || $past(st_q) != ST_RUN))
    else $error("low-supply reset not flagged");

  chk_lvr_keeps_thr : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (lvr_fire && !(wr_en && hit_thr) && !bad_done) |=> $stable(thr_q))
    else $error("threshold changed by low-supply reset");

  chk_bad_flag_set : assert property (
    @(posedge clk_i) disable iff (rst_i)
    bad_done |=> cause_q[BAD_BIT] && code_valid(thr_q))
    else $error("bad code flag not set");

  chk_flag_sticky : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cause_q[LVR_BIT] && !(wr_en && hit_cause)) |=> cause_q[LVR_BIT])
    else $error("cause flag cleared by hardware");

  chk_flags_never_drop : assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(wr_en && hit_cause) |=> (cause_q & $past(cause_q)) == $past(cause_q))
    else $error("cause flag dropped without software write");

  chk_wdt_flag_set : assert property (
    @(posedge clk_i) disable iff (rst_i)
    watchdog_ctrl_reset_i |=> cause_q[WDT_BIT])
    else $error("watchdog control flag not set");

  chk_unused_zero : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ack_o && $past(hit_width || hit_cause)) |-> dat_o[31:3] == '0)
    else $error("unimplemented bits read nonzero");

  chk_width_upper_zero : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ack_o && $past(hit_width)) |-> dat_o[31:2] == '0)
    else $error("width register upper bits read nonzero");

  chk_pd_no_fire : assert property (
    @(posedge clk_i) disable iff (rst_i)
    power_down_i [*2] |-> !lvr_fire)
    else $error("low-supply detect active in power-down");

  // Read clears status, but an event on the reading edge is kept
  chk_stat_read_clear : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_en && hit_stat) |=> stat_q == $past(events))
    else $error("status not cleared by read");

  chk_ack_one_cycle : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

endmodule : low_voltage_reset_control
`default_nettype wire

// >>> verilog/lvr_pkg.sv
// Package: constants, types and encodings of the low-voltage reset control
package lvr_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_MHZ            = 200;
  localparam int SOFT_RESET_DELAY_NS = 1000;
  localparam int SOFT_RESET_CYC     = (SOFT_RESET_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_PULSE_NS     = 100;
  localparam int RESET_PULSE_CYC    = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int          ADR_W         = 5;
  localparam logic [4:0]  ADR_THRESHOLD = 5'h00;
  localparam logic [4:0]  ADR_WIDTH     = 5'h04;
  localparam logic [4:0]  ADR_CAUSE     = 5'h08;
  localparam logic [4:0]  ADR_IRQ_STAT  = 5'h0C;
  localparam logic [4:0]  ADR_IRQ_MASK  = 5'h10;

  // ****************************************************************
  // Threshold codes and reset values
  // ****************************************************************
  localparam logic [7:0]  THR_2V10  = 8'h55;
  localparam logic [7:0]  THR_2V55  = 8'h33;
  localparam logic [7:0]  THR_3V15  = 8'h99;
  localparam logic [7:0]  THR_3V80  = 8'hAA;
  localparam logic [7:0]  THR_POR   = THR_2V10;
  localparam logic [1:0]  WIDTH_POR = 2'h0;

  // Low-speed oscillator periods per width code
  localparam logic [7:0]  WIDTH_CNT_0 = 8'h08;
  localparam logic [7:0]  WIDTH_CNT_1 = 8'h20;
  localparam logic [7:0]  WIDTH_CNT_2 = 8'h40;
  localparam logic [7:0]  WIDTH_CNT_3 = 8'h80;

  // ****************************************************************
  // Cause flag layout
  // ****************************************************************
  localparam int LVR_BIT = 2;
  localparam int BAD_BIT = 1;
  localparam int WDT_BIT = 0;
  localparam int FLAG_W  = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } wb_req_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_WAIT  = 2'b01,
    ST_RESET = 2'b10
  } seq_st_t;

endpackage : lvr_pkg

// >>> verilog/low_width_qualifier.sv
// Low-supply minimum-width qualifier counting low-speed oscillator periods
`timescale 1ns/100ps
`default_nettype none

module low_width_qualifier #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Qualification inputs
  input  wire logic       enable_i,
  input  wire logic       low_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] width_code_i,
  // Qualified event
  output logic            fire_o
);
  import lvr_pkg::*;

  generate
    if (CNT_W < 8) begin : g_chk
      $error("CNT_W too small for widest setting");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] target;
  logic             fired_q;
  logic             hit;

  assign target = (width_code_i == 2'h0) ? CNT_W'(WIDTH_CNT_0) :
                  (width_code_i == 2'h1) ? CNT_W'(WIDTH_CNT_1) :
                  (width_code_i == 2'h2) ? CNT_W'(WIDTH_CNT_2) :
                                           CNT_W'(WIDTH_CNT_3);
  // Phase of first tick is random, so N ticks span N-1 to N periods
  assign hit = tick_i && !fired_q && (cnt_q + 1'b1 == target);

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i || !low_i) begin
      cnt_q   <= '0;
      fired_q <= 1'b0;
      fire_o  <= 1'b0;
    end else begin
      fire_o <= hit;
      if (hit) fired_q <= 1'b1;
      if (tick_i && !fired_q) cnt_q <= cnt_q + 1'b1;
    end
  end

  chk_fire_needs_low : assert property (
    @(posedge clk_i) disable iff (rst_i)
    fire_o |-> $past(enable_i) && $past(low_i))
    else $error("qualified event without low supply");
  chk_count_restart : assert property (
    @(posedge clk_i) disable iff (rst_i)
    !low_i |=> cnt_q == '0)
    else $error("width counter did not restart");

endmodule : low_width_qualifier
`default_nettype wire

// >>> tb/supply_osc_model.sv
// Comparator and low-speed oscillator stand-in for the bench
`timescale 1ns/100ps
`default_nettype none

module supply_osc_model #(
  parameter real HALF_NS = 20.3
) (
  // Supply dip request from the bench
  input  wire logic low_req_i,
  // Pins seen by the block
  output logic      low_supply_o,
  output logic      osc_o
);
  // ****************************************************************
  // Oscillator
  // ****************************************************************
  // Runs free, phase unrelated to the bus clock
  initial begin
    osc_o = 1'b0;
    #3.1;
    forever #(HALF_NS) osc_o = ~osc_o;
  end

  // ****************************************************************
  // Comparator
  // ****************************************************************
  assign low_supply_o = low_req_i;
endmodule : supply_osc_model
`default_nettype wire

// >>> tb/test_low_voltage_reset_control.sv
// Self-checking bench of the low-voltage reset control
`timescale 1ns/100ps
`default_nettype none

module test_low_voltage_reset_control;
  import lvr_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int SR = 4;
  localparam int PL = 8;
  localparam logic [7:0] VC [4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
  logic             clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic             low_req, power_down_i, wd_i, low_w, osc_w;
  logic             chip_reset_o, irq_o;
  logic [ADR_W-1:0] adr_i;
  logic [3:0]       sel_i;
  logic [31:0]      dat_i, dat_o, rd;
  logic [7:0]       thr_o, code, thr;
  int               failures = 0, check_count = 0, rst_cnt = 0;
  int               hi_run = 0, last_len = 0, n, w;

  low_voltage_reset_control #(.SRESET_CYC(SR), .PULSE_CYC(PL))
    u_low_voltage_reset_control (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .low_supply_i(low_w),
    .low_speed_osc_i(osc_w), .power_down_i(power_down_i),
    .watchdog_ctrl_reset_i(wd_i), .threshold_code_o(thr_o),
    .chip_reset_o(chip_reset_o), .irq_o(irq_o));

  supply_osc_model u_supply_osc_model (
    .low_req_i(low_req), .low_supply_o(low_w), .osc_o(osc_w));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Reset pulses: count rises and record the length of the last one
  always @(posedge clk_i) begin
    if (chip_reset_o === 1'b1) begin
      if (hi_run == 0) rst_cnt <= rst_cnt + 1;
      hi_run <= hi_run + 1;
    end else if (hi_run != 0) begin
      last_len <= hi_run;
      hi_run <= 0;
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task wb(input logic w_en, input logic [4:0] a, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w_en;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= {24'h000000, d};
    // No local limit: only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task rdr(input logic [4:0] a);
    wb(1'b0, a, 8'h00);
  endtask : rdr

  // Osc edges, then back in step with the bus clock
  task ticks(input int k);
    repeat (k) @(posedge osc_w);
    @(posedge clk_i);
  endtask : ticks

  task wait_rst(input int base);
    int k;
    k = 0;
    while (rst_cnt == base && k < SR + 20) begin
      @(posedge clk_i);
      k++;
    end
    repeat (PL + 4) @(posedge clk_i);
  endtask : wait_rst

  function automatic int need(input int c);
    return (c == 0) ? 8 : (32 << (c - 1));
  endfunction : need

  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // Limit well above the longest dip sequence
  initial begin
    #300000;
    failures++;
    tally_and_finish();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {cyc_i, stb_i, we_i, low_req, power_down_i, wd_i} = 6'h00;
    adr_i = '0;
    sel_i = 4'h0;
    dat_i = 32'h0;
    rst_i = 1'b1;
    void'($urandom(32'h3653451A));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdr(ADR_THRESHOLD); check("threshold", rd, 32'h55);
    check("threshold pin", thr_o, 32'h55);
    rdr(ADR_WIDTH); check("width", rd, 32'h0);
    rdr(ADR_CAUSE); check("cause", rd, 32'h0);
    rdr(5'h1C); check("unmapped", rd, 32'h0);
    wb(1'b1, ADR_WIDTH, 8'hFF);
    rdr(ADR_WIDTH); check("width bits", rd, 32'h3);
    wb(1'b1, ADR_CAUSE, 8'hFF);
    rdr(ADR_CAUSE); check("cause bits", rd, 32'h0);
    $display("test registers done");
    foreach (VC[i]) begin
      wb(1'b1, ADR_THRESHOLD, VC[i]);
      repeat (SR + 12) @(posedge clk_i);
      rdr(ADR_THRESHOLD); check("valid code", rd, {24'h0, VC[i]});
      check("threshold pin", thr_o, {24'h0, VC[i]});
    end
    check("no reset", rst_cnt, 0);
    $display("test valid codes done");
    repeat (3) begin
      do code = 8'($urandom); while (code inside {8'h55, 8'h33, 8'h99, 8'hAA});
      n = rst_cnt;
      wb(1'b1, ADR_THRESHOLD, code);
      wait_rst(n);
      check("bad code reset", rst_cnt, n + 1);
      check("pulse length", last_len, PL);
      rdr(ADR_THRESHOLD); check("reload", rd, 32'h55);
      check("reload pin", thr_o, 32'h55);
      rdr(ADR_CAUSE); check("bad flag", rd, 32'h2);
    end
    wb(1'b1, ADR_CAUSE, 8'hFD);
    rdr(ADR_CAUSE); check("clear bit1", rd, 32'h0);
    $display("test bad codes done");
    wb(1'b1, ADR_IRQ_MASK, 8'h04);
    rdr(ADR_IRQ_STAT);
    for (w = 0; w < 4; w++) begin
      thr = VC[$urandom % 4];
      wb(1'b1, ADR_THRESHOLD, thr);
      wb(1'b1, ADR_WIDTH, w[7:0]);
      n = rst_cnt;
      low_req <= 1'b1;
      ticks(1 + $urandom % (need(w) - 3));
      low_req <= 1'b0;
      ticks(4);
      check("short dip", rst_cnt, n);
      low_req <= 1'b1;
      ticks(need(w) + 3);
      check("long dip", rst_cnt, n + 1);
      check("irq raised", irq_o, 1'b1);
      ticks(4);
      check("once per dip", rst_cnt, n + 1);
      low_req <= 1'b0;
      ticks(2);
      rdr(ADR_THRESHOLD); check("kept", rd, {24'h0, thr});
      check("kept pin", thr_o, {24'h0, thr});
      rdr(ADR_CAUSE); check("supply flag", rd, 32'h4);
      rdr(ADR_IRQ_STAT); check("status", rd, 32'h4);
      check("irq cleared", irq_o, 1'b0);
    end
    $display("test supply dips done");
    wb(1'b1, ADR_WIDTH, 8'h00);
    n = rst_cnt;
    power_down_i <= 1'b1;
    low_req <= 1'b1;
    ticks(20);
    low_req <= 1'b0;
    ticks(2);
    power_down_i <= 1'b0;
    check("power down", rst_cnt, n);
    wd_i <= 1'b1;
    @(posedge clk_i);
    wd_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("masked irq", irq_o, 1'b0);
    rdr(ADR_CAUSE); check("watchdog flag", rd, 32'h5);
    wb(1'b1, ADR_IRQ_MASK, 8'h01);
    check("irq unmasked", irq_o, 1'b1);
    rdr(ADR_IRQ_STAT); check("status wd", rd, 32'h1);
    check("irq low", irq_o, 1'b0);
    wb(1'b1, ADR_CAUSE, 8'h00);
    rdr(ADR_CAUSE); check("cleared", rd, 32'h0);
    $display("test power and watchdog done");
    tally_and_finish();
  end
endmodule : test_low_voltage_reset_control
`default_nettype wire
